// ==== supply_seq_pkg.sv ====
// Package for the power-on reset and I/O guard sequencer.
// Assumes a 200 MHz free-running timebase and synchronous supply-good inputs.
package supply_seq_pkg;

    localparam int CLK_MHZ        = 200;
    localparam int IO_BANK_COUNT  = 8;
    localparam int DELAY_LONG_MS  = 100;
    localparam int DELAY_SHORT_MS = 12;
    localparam int RISE_MAX_MS    = 100;
    localparam int CYCLES_PER_MS  = CLK_MHZ * 1000;
    localparam int DELAY_LONG_CYC  = DELAY_LONG_MS * CYCLES_PER_MS;
    localparam int DELAY_SHORT_CYC = DELAY_SHORT_MS * CYCLES_PER_MS;
    localparam int RISE_MAX_CYC    = RISE_MAX_MS * CYCLES_PER_MS;
    localparam int COUNT_W         = 25;

    typedef enum logic [2:0] {
        ST_RAMP,
        ST_DELAY,
        ST_CONFIG,
        ST_USER,
        ST_STALLED
    } seq_state_t;

    // Supply-good indications grouped as they arrive from the level monitors
    typedef struct packed {
        logic                     core_supply;
        logic                     predriver_supply;
        logic [IO_BANK_COUNT-1:0] io_bank_supply;
    } supply_good_t;

    // Per-pin output-buffer request from core logic
    typedef struct packed {
        logic drive;
        logic pad_above_io;
    } pin_req_t;

endpackage

// ==== power_on_reset_io_guard.sv ====
// Power-on reset sequencer with supply-low output guard.
// Assumes supply-good and pad-compare inputs are already synchronous to sys_clk.
//
// What this block does
// R1 - The supply-low guard is asserted whenever any core, I/O bank or pre-driver supply is low.
// R2 - While the guard is asserted every user output buffer is forced off.
// R3 - Configuration-complete, chain-enable-out and status pins are not gated by the guard.
// R4 - User I/O stays tristated from power-up until user mode is entered.
// R5 - Outputs stay off if the pad is above the I/O supply; I/O supply up before core holds them off only for the first cycle of user mode.
// R6 - The device is held in reset until all monitored supplies have stabilised.
// R7 - Configuration starts only once all eight bank supplies, pre-driver and core are good.
// R8 - In user mode a core supply sag resets the device.
// R9 - A reset sequence is produced only if supplies come up within the 100 ms rise limit.
// R10 - The delay-select pin low gives a 100 ms delay, high gives 12 ms.
// R11 - The delay-select level is sampled each time the supplies go good in the ramp state, and then held.
// R12 - A brown-out returns the sequencer to its initial state so the whole sequence repeats.
`timescale 1ns/1ps

module power_on_reset_io_guard
    import supply_seq_pkg::*;
#(
    parameter int DELAY_LONG  = DELAY_LONG_CYC,
    parameter int DELAY_SHORT = DELAY_SHORT_CYC,
    parameter int RISE_MAX    = RISE_MAX_CYC
) (
    input  wire logic         sys_clk,
    input  wire logic         reset,
    input  wire supply_good_t supply_good,
    input  wire logic         reset_delay_select,
    input  wire logic         config_done,
    input  wire pin_req_t     user_pin_req,
    input  wire logic         config_complete_pin_drive,
    input  wire logic         chain_enable_out_pin_drive,
    input  wire logic         config_status_pin_drive,
    output logic              supply_low_guard,
    output logic              device_reset,
    output logic              config_start,
    output logic              user_mode,
    output logic              user_pin_oe_n,
    output logic              config_complete_pin_oe_n,
    output logic              chain_enable_out_pin_oe_n,
    output logic              config_status_pin_oe_n
);

    seq_state_t         state;
    seq_state_t         next_state;
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] next_count;
    logic               delay_sel;
    logic               next_delay_sel;
    logic               core_seen;
    logic               next_core_seen;
    logic               io_first;
    logic               next_io_first;
    logic               all_good;
    logic               any_io_good;
    logic               guard;
    logic               next_user_oe_n;
    logic               next_cfg_oe_n;
    logic               next_chain_oe_n;
    logic               next_stat_oe_n;
    logic               next_device_reset;
    logic               next_config_start;
    logic               next_user_mode;

    function automatic logic [COUNT_W-1:0] to_count(input int value);
        return value[COUNT_W-1:0];
    endfunction

    assign all_good    = supply_good.core_supply & supply_good.predriver_supply
                         & (&supply_good.io_bank_supply); // R7
    assign any_io_good = |supply_good.io_bank_supply;
    assign guard       = ~all_good; // R1

    // Sequencer: ramp watch, delay, configuration, user mode
    always_comb begin
        next_state     = state;
        next_count     = count;
        next_delay_sel = delay_sel;
        unique case (state)
            ST_RAMP: begin
                if (all_good) begin
                    next_state     = ST_DELAY;
                    next_delay_sel = reset_delay_select; // R11
                    next_count     = '0;
                end else if (count >= to_count(RISE_MAX - 1)) begin
                    next_state = ST_STALLED; // R9
                end else begin
                    next_count = count + 1'h1;
                end
            end
            ST_DELAY: begin
                if (!all_good) begin
                    next_state = ST_RAMP; // R6
                    next_count = '0;
                end else if (count >= (delay_sel ? to_count(DELAY_SHORT - 1)
                                                 : to_count(DELAY_LONG - 1))) begin // R10
                    next_state = ST_CONFIG;
                end else begin
                    next_count = count + 1'h1;
                end
            end
            ST_CONFIG: begin
                if (!all_good) begin
                    next_state = ST_RAMP;
                    next_count = '0;
                end else if (config_done) begin
                    next_state = ST_USER;
                end
            end
            ST_USER: begin
                if (!supply_good.core_supply || !all_good) begin
                    next_state = ST_RAMP; // R8 R12
                    next_count = '0;
                end
            end
            ST_STALLED: begin
                // Supplies too slow: no sequence until a full power cycle drops all good
                if (!supply_good.core_supply && !any_io_good && !supply_good.predriver_supply) begin
                    next_state = ST_RAMP;
                    next_count = '0;
                end
            end
            default: begin
                next_state = ST_RAMP;
                next_count = '0;
            end
        endcase
    end

    // Order watch: I/O bank up while core still down keeps outputs off until user mode has lasted one cycle.
    // Core seen is kept until reset, so a bank that stays up through a brown-out
    // is not treated as having come up first.
    always_comb begin
        next_core_seen = core_seen | supply_good.core_supply;
        next_io_first  = io_first;
        if (any_io_good && !core_seen && !supply_good.core_supply) begin
            next_io_first = 1'h1; // R5
        end
        if (next_state == ST_RAMP && state != ST_RAMP) begin
            next_io_first = 1'h0;
        end
        if (state == ST_USER && next_state == ST_USER) begin
            next_io_first = 1'h0;
        end
    end

    // Pin enables, active low; registered so the pads never glitch
    always_comb begin
        next_user_oe_n  = 1'h1;
        if (next_state == ST_USER && !guard && !next_io_first  // R4
            && user_pin_req.drive && !user_pin_req.pad_above_io) begin // R5
            next_user_oe_n = 1'h0; // R2
        end
        next_cfg_oe_n   = ~config_complete_pin_drive; // R3
        next_chain_oe_n = ~chain_enable_out_pin_drive; // R3
        next_stat_oe_n  = ~config_status_pin_drive; // R3
    end

    // Status outputs follow the next state so they move on the same edge as the state
    always_comb begin
        next_device_reset = (next_state != ST_CONFIG) && (next_state != ST_USER); // R6
        next_config_start = (next_state == ST_CONFIG); // R7
        next_user_mode    = (next_state == ST_USER);
    end

    // Sequencer state; the rise timer and the reset delay share one counter
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state     <= ST_RAMP;
            count     <= '0;
            delay_sel <= 1'h0;
        end else begin
            state     <= next_state;
            count     <= next_count;
            delay_sel <= next_delay_sel;
        end
    end

    // Supply order memory
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            core_seen <= 1'h0;
            io_first  <= 1'h0;
        end else begin
            core_seen <= next_core_seen;
            io_first  <= next_io_first;
        end
    end

    // Pad enables start off, so no pad drives before the first clock edge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            user_pin_oe_n             <= 1'h1;
            config_complete_pin_oe_n  <= 1'h1;
            chain_enable_out_pin_oe_n <= 1'h1;
            config_status_pin_oe_n    <= 1'h1;
        end else begin
            user_pin_oe_n             <= next_user_oe_n;
            config_complete_pin_oe_n  <= next_cfg_oe_n;
            chain_enable_out_pin_oe_n <= next_chain_oe_n;
            config_status_pin_oe_n    <= next_stat_oe_n;
        end
    end

    // Status outputs; reset shows the device held with the guard up
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            supply_low_guard <= 1'h1;
            device_reset     <= 1'h1;
            config_start     <= 1'h0;
            user_mode        <= 1'h0;
        end else begin
            supply_low_guard <= guard; // R1
            device_reset     <= next_device_reset; // R6
            config_start     <= next_config_start; // R7
            user_mode        <= next_user_mode; // R4
        end
    end

endmodule // power_on_reset_io_guard

// ==== guard_sva.sv ====
// Checker bound onto the power-on reset sequencer ports.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module guard_sva
    import supply_seq_pkg::*;
#(parameter int DELAY_LONG = DELAY_LONG_CYC, parameter int DELAY_SHORT = DELAY_SHORT_CYC) (
    input wire logic         sys_clk,
    input wire logic         reset,
    input wire supply_good_t supply_good,
    input wire logic         reset_delay_select,
    input wire logic         supply_low_guard,
    input wire logic         device_reset,
    input wire logic         config_start,
    input wire logic         user_mode,
    input wire logic         user_pin_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [COUNT_W-1:0] dly;
    logic               sel_q;
    // Wait since the guard fell; select is the level seen while supplies came good
    always_ff @(posedge sys_clk or posedge reset)
        if (reset) {dly, sel_q} <= '0;
        else if (supply_low_guard) {dly, sel_q} <= {COUNT_W'(0), reset_delay_select};
        else dly <= dly + COUNT_W'(device_reset);
    sequence s_sag; user_mode && !supply_good.core_supply; endsequence
    sequence s_restart; !user_mode && device_reset && user_pin_oe_n && supply_low_guard; endsequence
    a_guard_low: assert property (!(&supply_good) |=> supply_low_guard)
        else $error("guard missed a low supply");
    a_guard_clear: assert property (&supply_good |=> !supply_low_guard)
        else $error("guard stuck with supplies good");
    a_guard_off: assert property (supply_low_guard |-> user_pin_oe_n)
        else $error("output on under guard");
    a_user_tristate: assert property (!user_mode |-> user_pin_oe_n)
        else $error("output on outside user mode");
    a_reset_hold: assert property (supply_low_guard |-> device_reset)
        else $error("reset released with supply low");
    a_start_good: assert property (config_start |-> !supply_low_guard)
        else $error("start with supply low");
    a_sag_restart: assert property (s_sag |=> s_restart)
        else $error("no restart on core sag");
    a_delay_count: assert property ($rose(config_start) |->
        int'(dly) == (sel_q ? DELAY_SHORT : DELAY_LONG)) else $error("wrong delay");
endmodule // guard_sva
bind power_on_reset_io_guard guard_sva #(.DELAY_LONG(DELAY_LONG), .DELAY_SHORT(DELAY_SHORT))
    u_sva (.sys_clk, .reset, .supply_good, .reset_delay_select, .supply_low_guard,
    .device_reset, .config_start, .user_mode, .user_pin_oe_n);

// ==== supply_cfg_partner.sv ====
// Supply monitors and configuration controller facing the sequencer.
// Assumes the bench chooses which supplies are up.
`timescale 1ns/1ps
module supply_cfg_partner
    import supply_seq_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire supply_good_t want,
    input  wire logic         config_start,
    input  wire logic         device_reset,
    output supply_good_t      supply_good,
    output logic              config_done
);
    logic [1:0] busy = 2'h0;
    assign supply_good = want;
    // Done four cycles into a start, forgotten once the device drops back into reset
    always @(posedge sys_clk) begin
        busy        <= config_start ? busy + 2'h1 : 2'h0;
        config_done <= !device_reset && (config_done || busy == 2'h3);
    end
endmodule // supply_cfg_partner

// ==== power_on_reset_io_guard_bench.sv ====
// Bench for the power-on reset sequencer with its supply partner.
// Assumes delays cut to 20 and 5 cycles and a rise limit of 50.
`timescale 1ns/1ps
module power_on_reset_io_guard_bench;
    import supply_seq_pkg::*;
    logic         sys_clk = 1'b0;
    logic         reset = 1'b1;
    logic         reset_delay_select = 1'b1;
    pin_req_t     user_pin_req = 2'h2;
    logic [2:0]   drv = 3'h5;
    logic [2:0]   cfg_oe;
    supply_good_t want = '0;
    supply_good_t supply_good;
    logic         config_done, supply_low_guard, device_reset, config_start, user_mode;
    logic         user_pin_oe_n;
    int           fails = 0;
    int           comparisons = 0;
    initial forever #2.5 sys_clk = ~sys_clk;
    power_on_reset_io_guard #(.DELAY_LONG(20), .DELAY_SHORT(5), .RISE_MAX(50)) u_dut (
        .sys_clk, .reset, .supply_good, .reset_delay_select, .config_done, .user_pin_req,
        .config_complete_pin_drive(drv[2]), .chain_enable_out_pin_drive(drv[1]),
        .config_status_pin_drive(drv[0]), .supply_low_guard, .device_reset, .config_start,
        .user_mode, .user_pin_oe_n, .config_complete_pin_oe_n(cfg_oe[2]),
        .chain_enable_out_pin_oe_n(cfg_oe[1]), .config_status_pin_oe_n(cfg_oe[0]));
    supply_cfg_partner u_partner (.sys_clk, .want, .config_start, .device_reset,
        .supply_good, .config_done);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        fails += int'(seen !== exp);
    endtask
    task automatic wrap_up;
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic power_up(input logic sel, input int dly);
        int n;
        n = 0;
        reset_delay_select = sel;
        want = '1;
        while (config_start !== 1'b1 && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        check(8'(n), 8'(dly + 1));
        if (n == 300) wrap_up();
        repeat (6) @(negedge sys_clk);
        check(8'(user_mode), 8'h01);
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        check(8'({supply_low_guard, device_reset, user_pin_oe_n, cfg_oe}), 8'h3A);
        want.io_bank_supply = 8'hFF;
        want.predriver_supply = 1'b1;
        repeat (3) @(negedge sys_clk);
        check(8'({supply_low_guard, config_start}), 8'h02);
        power_up(1'b1, 5);
        repeat (2) @(negedge sys_clk);
        check(8'(user_pin_oe_n), 8'h00);
        user_pin_req.pad_above_io = 1'h1;
        drv = 3'h2;
        repeat (2) @(negedge sys_clk);
        check(8'(user_pin_oe_n), 8'h01);
        check(8'(cfg_oe), 8'h05);
        user_pin_req.pad_above_io = 1'b0;
        want.core_supply = 1'b0;
        @(negedge sys_clk);
        check(8'({user_mode, device_reset, user_pin_oe_n, supply_low_guard}), 8'h07);
        repeat (60) @(negedge sys_clk);
        want = '1;
        repeat (40) @(negedge sys_clk);
        check(8'({config_start, device_reset}), 8'h01);
        want = '0;
        @(negedge sys_clk);
        power_up(1'b0, 20);
        wrap_up();
    end
endmodule // power_on_reset_io_guard_bench
